/* hdl/register_write_guard.sv */
`timescale 1ns/1ps
// Functional notes
// - Protected registers accept only sequenced stores
// - Only power save and clock control guarded
// - Reads need no unlock, leave flag
// - Any byte store to command arms
// - Command register reads return fixed filler
// - Status register byte and bit access
// - Error flag reads zero, one after violation
// - Protected store without preceding command sets error
// - Non-protected store after command sets error
// - Only zero write or reset clears flag
// - Power save entry deferred after store
module register_write_guard
  import write_guard_pkg::*;
#(
  parameter logic [3:0] PS_DELAY = PS_DELAY_CYC
)
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic [31:0] bus_addr_in,
  input wire logic bus_wr_in,
  input wire logic bus_rd_in,
  input wire logic [1:0] bus_size_in,
  input wire logic [2:0] bus_bit_in,
  input wire logic [7:0] bus_wdata_in,
  output logic [7:0] bus_rdata_out,
  output logic bus_rvalid_out,
  output logic [7:0] power_save_control_register_out,
  output logic [7:0] processor_clock_control_register_out,
  output logic protection_error_flag_out,
  output logic power_save_req_out
);

  localparam int PS_DLY_I = int'(PS_DELAY);

  guard_if gif ();

  logic hit_cmd;
  logic hit_psave;
  logic hit_pclk;
  logic hit_status;
  logic hit_any;
  logic status_wr;
  logic [7:0] store_val;
  logic [7:0] status_val;
  logic [7:0] status_wval;
  logic psave_commit;
  logic pclk_commit;

  logic [7:0] psave_r;
  logic [7:0] psave_nxt;
  logic [7:0] pclk_r;
  logic [7:0] pclk_nxt;
  logic err_r;
  logic err_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  logic pending_r;
  logic pending_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic req_r;
  logic req_nxt;

  // Byte store replaces the value, bit store changes one bit
  function automatic logic [7:0] merge_store(
    input logic [7:0] old_val,
    input logic [1:0] size,
    input logic [2:0] pos,
    input logic [7:0] wdata
  );
    logic [7:0] res;
    res = wdata;
    if (size == SZ_BIT)
    begin
      res = old_val;
      res[pos] = wdata[0];
    end
    return res;
  endfunction : merge_store

  // ==========================================================
  // Address decode and store classification
  assign hit_cmd = (bus_addr_in == CMD_ADDR);
  assign hit_psave = (bus_addr_in == PSAVE_ADDR);
  assign hit_pclk = (bus_addr_in == PCLK_ADDR);
  assign hit_status = (bus_addr_in == STATUS_ADDR);
  assign hit_any = hit_cmd | hit_psave | hit_pclk | hit_status;

  assign gif.store = bus_wr_in;
  assign gif.to_cmd = hit_cmd && (bus_size_in == SZ_BYTE);
  assign gif.to_prot = hit_psave | hit_pclk;

  unlock_sequencer u_seq (
    .clk_in(clk_in),
    .sys_rst_in(sys_rst_in),
    .gif(gif)
  );

  assign psave_commit = gif.commit && hit_psave;
  assign pclk_commit = gif.commit && hit_pclk;
  assign status_val = {7'h00, err_r};
  assign status_wr = bus_wr_in && hit_status;

  // ==========================================================
  // Protected registers and status flag
  always_comb
  begin
    store_val = BYTE_ZERO;
    status_wval = status_val;
    psave_nxt = psave_r;
    pclk_nxt = pclk_r;
    err_nxt = err_r;
    if (psave_commit)
    begin
      store_val = merge_store(psave_r, bus_size_in, bus_bit_in,
                              bus_wdata_in);
      psave_nxt = store_val;
    end
    else if (pclk_commit)
    begin
      store_val = merge_store(pclk_r, bus_size_in, bus_bit_in,
                              bus_wdata_in);
      pclk_nxt = store_val;
    end
    if (status_wr)
    begin
      status_wval = merge_store(status_val, bus_size_in, bus_bit_in,
                                bus_wdata_in);
      if (!status_wval[ERR_FLAG_BIT])
        err_nxt = 1'b0;
    end
    // Hardware set wins over a software clear in the same cycle
    if (gif.violation)
      err_nxt = 1'b1;
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      psave_r <= PSAVE_RST;
      pclk_r <= PCLK_RST;
      err_r <= 1'b0;
    end
    else
    begin
      psave_r <= psave_nxt;
      pclk_r <= pclk_nxt;
      err_r <= err_nxt;
    end
  end

  // ==========================================================
  // Deferred power save entry
  always_comb
  begin
    pending_nxt = pending_r;
    cnt_nxt = cnt_r;
    req_nxt = req_r;
    if (psave_commit)
    begin
      pending_nxt = psave_nxt[PSAVE_STOP_BIT];
      cnt_nxt = PS_DELAY;
      req_nxt = 1'b0;
    end
    else if (pending_r)
    begin
      cnt_nxt = cnt_r - 4'h1;
      if (cnt_r <= 4'h1)
      begin
        pending_nxt = 1'b0;
        req_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      pending_r <= 1'b0;
      cnt_r <= 4'h0;
      req_r <= 1'b0;
    end
    else
    begin
      pending_r <= pending_nxt;
      cnt_r <= cnt_nxt;
      req_r <= req_nxt;
    end
  end

  // ==========================================================
  // Read path
  always_comb
  begin
    rdata_nxt = BYTE_ZERO;
    rvalid_nxt = bus_rd_in && hit_any;
    if (bus_rd_in)
    begin
      if (hit_psave)
        rdata_nxt = psave_r;
      else if (hit_pclk)
        rdata_nxt = pclk_r;
      else if (hit_status)
        rdata_nxt = status_val;
      else if (hit_cmd)
        rdata_nxt = CMD_READ_VAL;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
    begin
      rdata_r <= BYTE_ZERO;
      rvalid_r <= 1'b0;
    end
    else
    begin
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign bus_rdata_out = rdata_r;
  assign bus_rvalid_out = rvalid_r;
  assign power_save_control_register_out = psave_r;
  assign processor_clock_control_register_out = pclk_r;
  assign protection_error_flag_out = err_r;
  assign power_save_req_out = req_r;

  // ==========================================================
  // Assertions
  sequence cmd_byte_store;
    bus_wr_in && hit_cmd && bus_size_in == SZ_BYTE;
  endsequence

  sequence psave_byte_store;
    bus_wr_in && hit_psave && bus_size_in == SZ_BYTE;
  endsequence

  a_unlock_commit: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    cmd_byte_store ##1 psave_byte_store |=>
      (psave_r == $past(bus_wdata_in)) && (err_r == $past(err_r))
  ) else $error("unlocked store did not land");

  a_lone_prot_err: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    bus_wr_in && gif.to_prot && !gif.armed |=>
      err_r && $stable(psave_r) && $stable(pclk_r)
  ) else $error("unsequenced protected store not flagged");

  a_stray_store: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    cmd_byte_store ##1 (bus_wr_in && !gif.to_prot) |=> err_r
  ) else $error("stray store after command not flagged");

  a_only_two: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    bus_wr_in && !gif.to_prot |=> $stable(psave_r) && $stable(pclk_r)
  ) else $error("guarded register changed by other store");

  a_read_no_effect: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    bus_rd_in && hit_psave && !bus_wr_in |=>
      bus_rvalid_out && bus_rdata_out == $past(psave_r) && $stable(err_r)
  ) else $error("protected read misbehaved");

  a_cmd_read: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    bus_rd_in && hit_cmd |=> bus_rdata_out == CMD_READ_VAL
  ) else $error("command read value wrong");

  a_clear_zero: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    status_wr && bus_size_in == SZ_BYTE && !bus_wdata_in[ERR_FLAG_BIT]
      && !gif.violation |=> !err_r
  ) else $error("zero write did not clear error");

  a_set_wins: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    gif.violation |=> err_r
  ) else $error("violation lost");

  a_err_sticky: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    err_r && !status_wr |=> err_r
  ) else $error("error flag dropped without clear");

  a_status_read: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    bus_rd_in && hit_status |=> bus_rdata_out == {7'h00, $past(err_r)}
  ) else $error("status read wrong");

  a_psave_defer: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    psave_commit && psave_nxt[PSAVE_STOP_BIT] ##1
      (!(bus_wr_in && hit_psave)) [*4] |->
      ##[0:PS_DLY_I] power_save_req_out
  ) else $error("power save not entered after delay");

  a_psave_late: assert property (
    @(posedge clk_in) disable iff (sys_rst_in)
    psave_commit |=> !power_save_req_out
  ) else $error("power save entered too early");

endmodule : register_write_guard

/* hdl/write_guard_pkg.sv */
package write_guard_pkg;

  // ==========================================================
  // Register map
  localparam logic [31:0] CMD_ADDR = 32'hfffff170;
  localparam logic [31:0] PSAVE_ADDR = 32'hfffff1f0;
  localparam logic [31:0] PCLK_ADDR = 32'hfffff074;
  localparam logic [31:0] STATUS_ADDR = 32'hfffff078;

  // ==========================================================
  // Access sizes on the peripheral bus
  localparam logic [1:0] SZ_BIT = 2'h0;
  localparam logic [1:0] SZ_BYTE = 2'h1;
  localparam logic [1:0] SZ_HALF = 2'h2;
  localparam logic [1:0] SZ_WORD = 2'h3;

  // ==========================================================
  // Fields and reset values
  localparam int ERR_FLAG_BIT = 0;
  localparam int PSAVE_STOP_BIT = 1;
  localparam logic [7:0] PSAVE_RST = 8'h00;
  localparam logic [7:0] PCLK_RST = 8'h00;
  localparam logic [7:0] CMD_READ_VAL = 8'h00;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // ==========================================================
  // Timing
  localparam logic [3:0] PS_DELAY_CYC = 4'h4;

  typedef enum logic {SEQ_IDLE, SEQ_ARMED} seq_state_e;

endpackage : write_guard_pkg

/* hdl/guard_if.sv */
`timescale 1ns/1ps
interface guard_if;
  logic store;
  logic to_cmd;
  logic to_prot;
  logic commit;
  logic violation;
  logic armed;

  modport core (output store, output to_cmd, output to_prot,
                input commit, input violation, input armed);
  modport seq (input store, input to_cmd, input to_prot,
               output commit, output violation, output armed);
endinterface : guard_if

/* hdl/unlock_sequencer.sv */
`timescale 1ns/1ps
module unlock_sequencer
  import write_guard_pkg::*;
(
  input wire logic clk_in,
  input wire logic sys_rst_in,
  guard_if.seq gif
);

  seq_state_e state_r;
  seq_state_e state_nxt;

  // ==========================================================
  // Store order tracking
  always_comb
  begin
    state_nxt = state_r;
    gif.commit = 1'b0;
    gif.violation = 1'b0;
    case (state_r)
      SEQ_IDLE:
      begin
        if (gif.store && gif.to_prot)
        begin
          gif.violation = 1'b1;
        end
        else if (gif.store && gif.to_cmd)
        begin
          state_nxt = SEQ_ARMED;
        end
      end
      SEQ_ARMED:
      begin
        if (gif.store)
        begin
          if (gif.to_prot)
          begin
            gif.commit = 1'b1;
            state_nxt = SEQ_IDLE;
          end
          else
          begin
            gif.violation = 1'b1;
            state_nxt = gif.to_cmd ? SEQ_ARMED : SEQ_IDLE;
          end
        end
      end
      default:
      begin
        state_nxt = SEQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (sys_rst_in)
      state_r <= SEQ_IDLE;
    else
      state_r <= state_nxt;
  end

  assign gif.armed = (state_r == SEQ_ARMED);

endmodule : unlock_sequencer

/* bench/core_bus_model.sv */
`timescale 1ns/1ps
module core_bus_model
  import write_guard_pkg::*;
(
  input wire logic clk_in,
  input wire logic [7:0] bus_rdata_in,
  input wire logic bus_rvalid_in,
  output logic [31:0] bus_addr_out,
  output logic bus_wr_out,
  output logic bus_rd_out,
  output logic [1:0] bus_size_out,
  output logic [2:0] bus_bit_out,
  output logic [7:0] bus_wdata_out
);
  logic nonmaskable_pending_bit = 1'b0;

  initial
  begin
    bus_addr_out = 32'h0;
    bus_wr_out = 1'b0;
    bus_rd_out = 1'b0;
    bus_size_out = SZ_BYTE;
    bus_bit_out = 3'h0;
    bus_wdata_out = 8'h00;
  end

  // ==========================================================
  // Bus cycles, entered and left at a falling edge
  task automatic store(input logic [31:0] a, input logic [1:0] sz,
                       input logic [2:0] pos, input logic [7:0] d);
    bus_wr_out = 1'b1;
    bus_rd_out = 1'b0;
    bus_addr_out = a;
    bus_size_out = sz;
    bus_bit_out = pos;
    bus_wdata_out = d;
    @(negedge clk_in);
  endtask : store

  task automatic load(input logic [31:0] a, output logic [7:0] d,
                      output logic v);
    bus_rd_out = 1'b1;
    bus_wr_out = 1'b0;
    bus_addr_out = a;
    bus_size_out = SZ_BYTE;
    @(negedge clk_in);
    d = bus_rdata_in;
    v = bus_rvalid_in;
  endtask : load

  // Idle cycle stands in for no-op padding; stale address and data are inverted
  task automatic rest();
    bus_wr_out = 1'b0;
    bus_rd_out = 1'b0;
    bus_addr_out = ~bus_addr_out;
    bus_wdata_out = ~bus_wdata_out;
    @(negedge clk_in);
  endtask : rest

  // Protected sequence as software runs it, pending bit set around it
  task automatic guarded_store(input logic [31:0] a, input logic [7:0] d);
    logic saved_pending;
    saved_pending = nonmaskable_pending_bit;
    nonmaskable_pending_bit = 1'b1;
    store(CMD_ADDR, SZ_BYTE, 3'h0, ~d);
    store(a, SZ_BYTE, 3'h0, d);
    nonmaskable_pending_bit = saved_pending;
    rest();
  endtask : guarded_store
endmodule : core_bus_model

/* bench/specific_register_write_guard_tb_top.sv */
`timescale 1ns/1ps
module specific_register_write_guard_tb_top
  import write_guard_pkg::*;
;
  localparam logic [3:0] PSD = 4'h3;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [31:0] addr;
  logic wr, rd, rvalid, flag, req;
  logic [1:0] size;
  logic [2:0] bitp;
  logic [7:0] wdata, rdata, psave_q, pclk_q;
  int fail_count = 0;
  int n_compared = 0;

  always #12.5 clk_in = ~clk_in;

  register_write_guard #(.PS_DELAY(PSD)) dut (.clk_in(clk_in),
    .sys_rst_in(sys_rst_in), .bus_addr_in(addr), .bus_wr_in(wr),
    .bus_rd_in(rd), .bus_size_in(size), .bus_bit_in(bitp),
    .bus_wdata_in(wdata), .bus_rdata_out(rdata), .bus_rvalid_out(rvalid),
    .power_save_control_register_out(psave_q),
    .processor_clock_control_register_out(pclk_q),
    .protection_error_flag_out(flag), .power_save_req_out(req));

  core_bus_model core (.clk_in(clk_in), .bus_rdata_in(rdata),
    .bus_rvalid_in(rvalid), .bus_addr_out(addr), .bus_wr_out(wr),
    .bus_rd_out(rd), .bus_size_out(size), .bus_bit_out(bitp),
    .bus_wdata_out(wdata));

  // ==========================================================
  // Shared helpers
  task automatic check(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic rd_check(input logic [31:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic v;
    core.load(a, d, v);
    check({7'h0, v}, 8'h01, "read valid");
    check(d, exp, "read data");
  endtask : rd_check

  task automatic unlock_wr(input logic [31:0] a, input logic [7:0] d);
    core.guarded_store(a, d);
  endtask : unlock_wr

  task automatic clear_flag();
    core.store(STATUS_ADDR, SZ_BIT, 3'h0, 8'h00);
    core.rest();
  endtask : clear_flag

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out

  // ==========================================================
  // Scenarios
  task automatic s_reset();
    check(psave_q, PSAVE_RST, "psave reset");
    check(pclk_q, PCLK_RST, "pclk reset");
    rd_check(STATUS_ADDR, 8'h00);
    rd_check(CMD_ADDR, CMD_READ_VAL);
  endtask : s_reset

  task automatic s_unlock();
    logic [7:0] codes [3] = '{8'h00, 8'h5a, 8'hff};
    foreach (codes[i])
    begin
      unlock_wr(PCLK_ADDR, codes[i]);
      check(pclk_q, codes[i], "clock write");
      check({7'h0, flag}, 8'h00, "flag after unlock");
    end
    unlock_wr(PSAVE_ADDR, 8'h01);
    check(psave_q, 8'h01, "psave write");
  endtask : s_unlock

  task automatic s_reads();
    core.store(CMD_ADDR, SZ_BYTE, 3'h0, 8'h77);
    core.rest();
    rd_check(PSAVE_ADDR, 8'h01);
    rd_check(PCLK_ADDR, 8'hff);
    core.store(PSAVE_ADDR, SZ_BYTE, 3'h0, 8'h0d);
    core.rest();
    check(psave_q, 8'h0d, "write after reads");
    check({7'h0, flag}, 8'h00, "flag after reads");
  endtask : s_reads

  task automatic s_violate();
    core.store(PCLK_ADDR, SZ_BYTE, 3'h0, 8'h33);
    core.rest();
    check(pclk_q, 8'hff, "dropped store");
    rd_check(STATUS_ADDR, 8'h01);
    core.store(STATUS_ADDR, SZ_BYTE, 3'h0, 8'h01);
    core.rest();
    check({7'h0, flag}, 8'h01, "one keeps flag");
    clear_flag();
    check({7'h0, flag}, 8'h00, "bit clear");
  endtask : s_violate

  task automatic s_wrong_next();
    core.store(CMD_ADDR, SZ_BYTE, 3'h0, 8'h12);
    core.store(32'hfffff100, SZ_BYTE, 3'h0, 8'h34);
    core.rest();
    check({7'h0, flag}, 8'h01, "other after command");
    core.store(CMD_ADDR, SZ_BYTE, 3'h0, 8'h12);
    core.store(STATUS_ADDR, SZ_BYTE, 3'h0, 8'h00);
    core.rest();
    check({7'h0, flag}, 8'h01, "set beats clear");
    core.store(STATUS_ADDR, SZ_BYTE, 3'h0, 8'h00);
    core.rest();
    check({7'h0, flag}, 8'h00, "byte clear");
    core.store(CMD_ADDR, SZ_HALF, 3'h0, 8'h12);
    core.store(PSAVE_ADDR, SZ_BYTE, 3'h0, 8'h41);
    core.rest();
    check(psave_q, 8'h0d, "half command no arm");
    check({7'h0, flag}, 8'h01, "half command err");
    clear_flag();
    core.store(32'hfffff100, SZ_BYTE, 3'h0, 8'h55);
    core.rest();
    check({7'h0, flag}, 8'h00, "unguarded store");
  endtask : s_wrong_next

  task automatic s_power();
    int k;
    core.store(CMD_ADDR, SZ_BYTE, 3'h0, 8'h00);
    core.store(PSAVE_ADDR, SZ_BYTE, 3'h0, 8'h02);
    check({7'h0, req}, 8'h00, "req low at commit");
    core.rest();
    // One clock edge has passed since the commit edge
    k = 1;
    while (req !== 1'b1 && k < 12)
    begin
      @(negedge clk_in);
      k++;
    end
    if (k >= 12)
    begin
      fail_count++;
      $display("unexpected at %0t: power save request never rose", $time);
      close_out();
    end
    check(8'(k), 8'(PSD), "power save delay");
    unlock_wr(PSAVE_ADDR, 8'h00);
    check({7'h0, req}, 8'h00, "request dropped");
  endtask : s_power

  task automatic s_mid_reset();
    core.store(PSAVE_ADDR, SZ_BYTE, 3'h0, 8'h10);
    core.store(CMD_ADDR, SZ_BYTE, 3'h0, 8'h10);
    core.rest();
    check({7'h0, flag}, 8'h01, "flag before reset");
    // Reset lands while the sequencer is armed
    sys_rst_in = 1'b1;
    repeat (2) @(negedge clk_in);
    sys_rst_in = 1'b0;
    @(negedge clk_in);
    check({7'h0, flag}, 8'h00, "reset clears flag");
    check(pclk_q, PCLK_RST, "reset clock reg");
    core.store(PSAVE_ADDR, SZ_BYTE, 3'h0, 8'h10);
    core.rest();
    check(psave_q, PSAVE_RST, "reset disarms");
    check({7'h0, flag}, 8'h01, "store after reset");
    clear_flag();
    check({7'h0, flag}, 8'h00, "final clear");
  endtask : s_mid_reset

  initial
  begin
    repeat (12) @(negedge clk_in);
    sys_rst_in = 1'b0;
    @(negedge clk_in);
    s_reset();
    s_unlock();
    s_reads();
    s_violate();
    s_wrong_next();
    s_power();
    s_mid_reset();
    close_out();
  end
endmodule : specific_register_write_guard_tb_top
